// ===== logic/nvsp_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - read: chip select and output enable low, write strobe and store-busy high
// - write: chip select and write strobe low, store-busy high
// - host holds address stable until chip select or write strobe rise
// - host keeps output enable high for the whole write
// - six reads at fixed addresses, ending 0x8fc0, start a software store
module nvsp_host #(
  parameter int ADDR_W = nvsp_pkg::ADDR_W_X16,
  parameter int DATA_W = 16,
  parameter int HW_PULL_CYC = 2,
  parameter int SW_STORE_CYC = 1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user request port
  input wire nvsp_pkg::nvsp_req_t req,
  input wire logic reqValid,
  input wire logic storeReq,
  input wire logic swStoreReq,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic storeDone,
  // memory pins
  output nvsp_pkg::nvsp_strobe_t strobes,
  output logic [ADDR_W-1:0] address_bus,
  input wire logic [DATA_W-1:0] dataBusIn,
  output logic [DATA_W-1:0] dataBusOut,
  output logic dataBusOe,
  input wire logic storeBusyNIn,
  output logic storeBusyNOut,
  output logic storeBusyNOe
);

  if (!((DATA_W == 16 && ADDR_W == nvsp_pkg::ADDR_W_X16) || (DATA_W == 8 && ADDR_W == nvsp_pkg::ADDR_W_X8)))
  begin : g_bad_org
    $error("nvsp_host: organisation must be x8 with 19 address bits or x16 with 18");
  end
  if (HW_PULL_CYC < 1 || SW_STORE_CYC < 1 || SW_STORE_CYC > 65535 || HW_PULL_CYC > 65535)
  begin : g_bad_cnt
    $error("nvsp_host: counts must lie in 1..65535");
  end

  localparam logic [nvsp_pkg::CNT_W-1:0] RD_CNT = nvsp_pkg::CNT_W'(nvsp_pkg::ACCESS_CYC + nvsp_pkg::SYNC_DEPTH - 1);
  localparam logic [nvsp_pkg::CNT_W-1:0] WR_CNT = nvsp_pkg::CNT_W'(nvsp_pkg::ACCESS_CYC - 1);
  localparam logic [nvsp_pkg::CNT_W-1:0] PULL_CNT = nvsp_pkg::CNT_W'(HW_PULL_CYC - 1);
  localparam logic [nvsp_pkg::CNT_W-1:0] SWW_CNT = nvsp_pkg::CNT_W'(SW_STORE_CYC - 1);
  localparam logic [nvsp_pkg::CNT_W-1:0] GUARD_CNT = nvsp_pkg::CNT_W'(nvsp_pkg::BUSY_GUARD_CYC - 1);

  nvsp_pkg::nvsp_state_t state_r, state_nxt;
  nvsp_pkg::nvsp_strobe_t strobes_r;
  logic [nvsp_pkg::CNT_W-1:0] cnt_r;
  logic [2:0] step_r;
  logic swSeq_r, write_r, reqReady_r, rspValid_r, storeDone_r, dataBusOe_r, storeBusyNOe_r, storeBusyNOut_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] dataOut_r, rspData_r, dataSync1_r, dataSync2_r;
  logic busySync1_r, busySync2_r;

  // pin inputs pass two flops before use
  always_ff @(posedge clk)
  begin
    dataSync1_r <= dataBusIn;
    dataSync2_r <= dataSync1_r;
    busySync1_r <= storeBusyNIn;
    busySync2_r <= busySync1_r;
  end

  wire logic busHigh = busySync2_r;
  wire logic takeMem = reqValid && reqReady_r;
  wire logic takeHw = storeReq && reqReady_r && !reqValid;
  wire logic takeSw = swStoreReq && reqReady_r && !reqValid && !storeReq;
  wire logic cntZero = (cnt_r == nvsp_pkg::CNT_RESET);
  wire logic seqMore = swSeq_r && (step_r != nvsp_pkg::SEQ_LAST);
  wire logic [2:0] stepNext = step_r + 3'h1;
  wire logic [ADDR_W-1:0] seqAddr0 = {{(ADDR_W-16){1'b0}}, nvsp_pkg::SW_STORE_SEQ[0]};
  wire logic [ADDR_W-1:0] seqAddrNext = {{(ADDR_W-16){1'b0}}, nvsp_pkg::SW_STORE_SEQ[stepNext]};
  wire logic [DATA_W-1:0] laneMask;
  wire logic [1:0] reqLaneN = ~req.byteEn;

  // byte lanes not enabled read back as zero
  if (DATA_W == 16)
  begin : g_x16
    assign laneMask = {{8{~strobes_r.upperByteEnableN}}, {8{~strobes_r.lowerByteEnableN}}};
  end
  else
  begin : g_x8
    assign laneMask = {DATA_W{1'b1}};
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      nvsp_pkg::NVSP_IDLE:
        if (takeMem || takeSw)
          state_nxt = nvsp_pkg::NVSP_SETUP;
        else if (takeHw)
          state_nxt = nvsp_pkg::NVSP_HWPULL;
      nvsp_pkg::NVSP_SETUP:
        state_nxt = nvsp_pkg::NVSP_STROBE;
      nvsp_pkg::NVSP_STROBE:
        if (cntZero)
          state_nxt = nvsp_pkg::NVSP_RELEASE;
      nvsp_pkg::NVSP_RELEASE:
        if (seqMore)
          state_nxt = nvsp_pkg::NVSP_NEXT;
        else if (swSeq_r)
          state_nxt = nvsp_pkg::NVSP_SWWAIT;
        else
          state_nxt = nvsp_pkg::NVSP_IDLE;
      nvsp_pkg::NVSP_NEXT:
        state_nxt = nvsp_pkg::NVSP_SETUP;
      nvsp_pkg::NVSP_SWWAIT:
        if (cntZero)
          state_nxt = nvsp_pkg::NVSP_WAITBUSY;
      nvsp_pkg::NVSP_HWPULL:
        if (cntZero)
          state_nxt = nvsp_pkg::NVSP_WAITBUSY;
      nvsp_pkg::NVSP_WAITBUSY:
        if (cntZero && busHigh)
          state_nxt = nvsp_pkg::NVSP_IDLE;
      default:
        state_nxt = nvsp_pkg::NVSP_IDLE;
    endcase
  end

  // new accesses only start while store-busy reads high
  wire logic readyNxt = (state_nxt == nvsp_pkg::NVSP_IDLE) && busHigh;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= nvsp_pkg::NVSP_IDLE;
      strobes_r <= nvsp_pkg::STROBE_IDLE;
      cnt_r <= nvsp_pkg::CNT_RESET;
      step_r <= nvsp_pkg::STEP_RESET;
      swSeq_r <= 1'b0;
      write_r <= 1'b0;
      reqReady_r <= 1'b0;
      rspValid_r <= 1'b0;
      storeDone_r <= 1'b0;
      dataBusOe_r <= 1'b0;
      storeBusyNOe_r <= 1'b0;
      storeBusyNOut_r <= 1'b0;
      addr_r <= '0;
      dataOut_r <= '0;
      rspData_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      reqReady_r <= readyNxt;
      rspValid_r <= 1'b0;
      storeDone_r <= 1'b0;
      storeBusyNOut_r <= 1'b0;
      case (state_r)
        nvsp_pkg::NVSP_IDLE:
          if (takeMem)
          begin
            // chip select falls in the same cycle that the address is loaded
            write_r <= req.write;
            addr_r <= req.addr[ADDR_W-1:0];
            dataOut_r <= req.wdata[DATA_W-1:0];
            dataBusOe_r <= req.write;
            strobes_r.ceN <= 1'b0;
            strobes_r.oeN <= req.write;
            strobes_r.upperByteEnableN <= (DATA_W == 16) ? reqLaneN[1] : 1'b1;
            strobes_r.lowerByteEnableN <= (DATA_W == 16) ? reqLaneN[0] : 1'b0;
          end
          else if (takeHw)
          begin
            cnt_r <= PULL_CNT;
            storeBusyNOe_r <= 1'b1;
          end
          else if (takeSw)
          begin
            swSeq_r <= 1'b1;
            step_r <= nvsp_pkg::STEP_RESET;
            write_r <= 1'b0;
            addr_r <= seqAddr0;
            strobes_r <= nvsp_pkg::STROBE_IDLE;
            strobes_r.ceN <= 1'b0;
            strobes_r.oeN <= 1'b0;
          end
        nvsp_pkg::NVSP_SETUP:
        begin
          cnt_r <= write_r ? WR_CNT : RD_CNT;
          strobes_r.weN <= !write_r;
        end
        nvsp_pkg::NVSP_STROBE:
          if (cntZero)
          begin
            strobes_r.weN <= 1'b1;
            if (!write_r)
              rspData_r <= dataSync2_r & laneMask;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        nvsp_pkg::NVSP_RELEASE:
        begin
          // address and data stay put until chip select is back high
          strobes_r.ceN <= 1'b1;
          strobes_r.oeN <= 1'b1;
          dataBusOe_r <= 1'b0;
          if (seqMore)
          begin
            step_r <= stepNext;
            addr_r <= seqAddrNext;
          end
          else if (swSeq_r)
          begin
            swSeq_r <= 1'b0;
            cnt_r <= SWW_CNT;
          end
          else
            rspValid_r <= 1'b1;
        end
        nvsp_pkg::NVSP_NEXT:
        begin
          strobes_r.ceN <= 1'b0;
          strobes_r.oeN <= 1'b0;
        end
        nvsp_pkg::NVSP_SWWAIT:
          if (cntZero)
            cnt_r <= GUARD_CNT;
          else
            cnt_r <= cnt_r - 16'h0001;
        nvsp_pkg::NVSP_HWPULL:
          if (cntZero)
          begin
            storeBusyNOe_r <= 1'b0;
            cnt_r <= GUARD_CNT;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        nvsp_pkg::NVSP_WAITBUSY:
          if (!cntZero)
            cnt_r <= cnt_r - 16'h0001;
          else if (busHigh)
            storeDone_r <= 1'b1;
        default:
          strobes_r <= nvsp_pkg::STROBE_IDLE;
      endcase
    end
  end

  assign reqReady = reqReady_r;
  assign rspValid = rspValid_r;
  assign rspData = rspData_r;
  assign storeDone = storeDone_r;
  assign strobes = strobes_r;
  assign address_bus = addr_r;
  assign dataBusOut = dataOut_r;
  assign dataBusOe = dataBusOe_r;
  assign storeBusyNOut = storeBusyNOut_r;
  assign storeBusyNOe = storeBusyNOe_r;

  chk_read_we_high: assert property (@(posedge clk) disable iff (srst)
    (!strobes_r.ceN && !strobes_r.oeN) |-> (strobes_r.weN && !dataBusOe_r))
    else $error("read strobes active while write strobe or data drive on");

  chk_write_start_free: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes_r.weN) |-> (!strobes_r.ceN && !storeBusyNOe_r && $past(busySync2_r, 3)))
    else $error("write strobe fell without chip select or while store-busy low");

  chk_write_addr_hold: assert property (@(posedge clk) disable iff (srst)
    (!strobes_r.weN) |=> ($stable(addr_r) && !strobes_r.ceN))
    else $error("address or chip select moved before write strobe rose");

  chk_write_oe_high: assert property (@(posedge clk) disable iff (srst)
    (!strobes_r.ceN && dataBusOe_r) |-> strobes_r.oeN)
    else $error("output enable low while host drives write data");

  chk_seq_addr_order: assert property (@(posedge clk) disable iff (srst)
    (swSeq_r && $fell(strobes_r.ceN)) |-> (addr_r[15:0] == nvsp_pkg::SW_STORE_SEQ[step_r] && strobes_r.weN))
    else $error("software store read at wrong address");

  chk_seq_ends_last: assert property (@(posedge clk) disable iff (srst)
    (state_r == nvsp_pkg::NVSP_SWWAIT && $past(state_r) == nvsp_pkg::NVSP_RELEASE)
      |-> ($past(addr_r[15:0]) == 16'h8fc0 && !rspValid_r))
    else $error("software store wait entered before final sequence read");

  chk_ready_busy_high: assert property (@(posedge clk) disable iff (srst)
    reqReady_r |-> ($past(busySync2_r) && strobes_r.ceN && !storeBusyNOe_r))
    else $error("ready raised while store-busy low or access open");

endmodule

// ===== logic/nvsp_pkg.sv
package nvsp_pkg;

  // pin and clock timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_ACCESS_NS = 45;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_DEPTH = 2;
  localparam int BUSY_GUARD_CYC = 4;
  localparam int CNT_W = 16;

  // organisation
  localparam int ADDR_W_X8 = 19;
  localparam int ADDR_W_X16 = 18;
  localparam int SEQ_LEN = 6;
  localparam logic [2:0] SEQ_LAST = 3'h5;

  // software store address sequence, entry 0 first
  localparam logic [SEQ_LEN-1:0][15:0] SW_STORE_SEQ =
    {16'h8fc0, 16'h703f, 16'h7c1f, 16'h83e0, 16'hb1c7, 16'h4e38};

  // values after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] STEP_RESET = 3'h0;

  typedef enum logic [2:0]
  {
    NVSP_IDLE = 3'b000,
    NVSP_SETUP = 3'b001,
    NVSP_STROBE = 3'b011,
    NVSP_RELEASE = 3'b010,
    NVSP_NEXT = 3'b110,
    NVSP_SWWAIT = 3'b111,
    NVSP_WAITBUSY = 3'b101,
    NVSP_HWPULL = 3'b100
  } nvsp_state_t;

  // active-low strobes driven onto the memory
  typedef struct packed
  {
    logic ceN;
    logic weN;
    logic oeN;
    logic upperByteEnableN;
    logic lowerByteEnableN;
  } nvsp_strobe_t;

  localparam nvsp_strobe_t STROBE_IDLE = 5'h1f;

  // user access request, widest organisation
  typedef struct packed
  {
    logic write;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [1:0] byteEn;
  } nvsp_req_t;

endpackage

// ===== verification/nvsp_mem_model.sv
`timescale 1ns/1ps
module nvsp_mem_model #(
  parameter int STORE_CYC = 20,
  parameter int DELAY_CYC = 1,
  parameter int RECALL_CYC = 10,
  parameter bit AUTO_EN = 1'b1
) (
  // host side pins
  input wire logic clk,
  input wire nvsp_pkg::nvsp_strobe_t strobes,
  input wire logic [17:0] address_bus,
  input wire logic [15:0] dataBusOut,
  input wire logic dataBusOe,
  input wire logic storeBusyN,
  // supply monitor
  input wire logic supplyLow,
  // device side
  output logic [15:0] dataBusIn,
  output logic pullBusy,
  output int storeCount,
  output int recallCount,
  output int protoErr
);
  logic [15:0] mem [0:255];
  logic [15:0] lastIn = 16'h0000;
  logic [15:0] rdWord;
  logic [15:0] seqAddr = 16'h0000;
  logic writeSeen = 1'b0;
  logic selOk = 1'b0;
  logic recallPend = 1'b0;
  nvsp_pkg::nvsp_strobe_t prev = nvsp_pkg::STROBE_IDLE;
  int busyCnt = 0;
  int dly = 0;
  int step = 0;
  wire reading = !strobes.ceN && !strobes.oeN && strobes.weN && storeBusyN && busyCnt == 0;
  wire upOn = reading && !strobes.upperByteEnableN;
  wire loOn = reading && !strobes.lowerByteEnableN;

  initial
  begin
    storeCount = 0;
    recallCount = 0;
    protoErr = 0;
  end

  // undriven lanes toggle so a stale value never reads as valid
  assign rdWord = mem[address_bus[7:0]];
  assign dataBusIn[15:8] = upOn ? rdWord[15:8] : ~lastIn[15:8];
  assign dataBusIn[7:0] = loOn ? rdWord[7:0] : ~lastIn[7:0];
  assign pullBusy = busyCnt != 0;

  always @(posedge clk)
  begin
    lastIn <= dataBusIn;
    prev <= strobes;
    if ((dataBusOe && reading) || (!strobes.ceN && busyCnt != 0))
      protoErr <= protoErr + 1;
    if (prev.ceN && !strobes.ceN)
    begin
      seqAddr <= address_bus[15:0];
      // a write is only accepted if it began while store-busy was high
      selOk <= storeBusyN && busyCnt == 0;
    end
    if (!prev.ceN && strobes.ceN && prev.weN)
      step <= (seqAddr == nvsp_pkg::SW_STORE_SEQ[step]) ? step + 1 : 0;
    if (!prev.ceN && !prev.weN && (strobes.weN || strobes.ceN) && selOk && busyCnt == 0)
    begin
      if (!prev.upperByteEnableN)
        mem[seqAddr[7:0]][15:8] <= dataBusOut[15:8];
      if (!prev.lowerByteEnableN)
        mem[seqAddr[7:0]][7:0] <= dataBusOut[7:0];
      writeSeen <= 1'b1;
      step <= 0;
    end
    if (supplyLow)
      recallPend <= 1'b1;
    if (busyCnt != 0)
    begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == 1)
      begin
        writeSeen <= 1'b0;
        // a pending recall follows the store without releasing the line
        if (recallPend && !supplyLow)
        begin
          recallPend <= 1'b0;
          busyCnt <= RECALL_CYC;
          recallCount <= recallCount + 1;
        end
      end
    end
    else if (step == nvsp_pkg::SEQ_LEN)
    begin
      step <= 0;
      busyCnt <= STORE_CYC;
      storeCount <= storeCount + 1;
    end
    else if (dly != 0)
    begin
      // an access still selected finishes before the store begins
      if (strobes.ceN)
      begin
        dly <= dly - 1;
        if (dly == 1 && writeSeen)
        begin
          busyCnt <= STORE_CYC;
          storeCount <= storeCount + 1;
        end
      end
    end
    else if (recallPend && !supplyLow)
    begin
      recallPend <= 1'b0;
      busyCnt <= RECALL_CYC;
      recallCount <= recallCount + 1;
    end
    else if (!storeBusyN || (supplyLow && AUTO_EN))
      dly <= DELAY_CYC;
  end
endmodule

// ===== verification/nvsp_host_tb.sv
`timescale 1ns/1ps
module nvsp_host_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  nvsp_pkg::nvsp_req_t req = '0;
  logic reqValid = 1'b0;
  logic storeReq = 1'b0;
  logic swStoreReq = 1'b0;
  logic reqReady, rspValid, storeDone, dataBusOe, storeBusyNOut, storeBusyNOe, pullBusy;
  logic [15:0] rspData, dataBusIn, dataBusOut, rdVal;
  logic [17:0] address_bus;
  nvsp_pkg::nvsp_strobe_t strobes;
  int storeCount, protoErr, recallCount;
  int fail_count = 0;
  int n_checks = 0;
  logic supplyLow = 1'b0;
  logic extPull = 1'b0;
  // open-drain line with pull-up; a third party may pull it as well
  wire storeBusyN = !(storeBusyNOe && !storeBusyNOut) && !pullBusy && !extPull;

  nvsp_host #(.SW_STORE_CYC(30)) nvsp_host_inst (.clk(clk), .srst(srst), .req(req), .reqValid(reqValid),
    .storeReq(storeReq), .swStoreReq(swStoreReq), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .storeDone(storeDone), .strobes(strobes), .address_bus(address_bus),
    .dataBusIn(dataBusIn), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
    .storeBusyNIn(storeBusyN), .storeBusyNOut(storeBusyNOut), .storeBusyNOe(storeBusyNOe));

  nvsp_mem_model nvsp_mem_model_inst (.clk(clk), .strobes(strobes), .address_bus(address_bus),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe), .storeBusyN(storeBusyN), .supplyLow(supplyLow),
    .dataBusIn(dataBusIn), .pullBusy(pullBusy), .storeCount(storeCount), .recallCount(recallCount),
    .protoErr(protoErr));

  initial forever #20 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic await(ref logic sig, input string what);
    int n;
    n = 0;
    // registered outputs are looked at mid-cycle, where they are settled
    while (sig !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check(what, {31'h0, sig}, 32'h1);
  endtask

  task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge clk);
    req = '{write: wr, addr: {1'b0, a}, wdata: d, byteEn: be};
    reqValid = 1'b1;
    await(reqReady, "ready");
    @(negedge clk);
    reqValid = 1'b0;
    await(rspValid, "response");
    rdVal = rspData;
  endtask

  task automatic store(input logic sw, input int expCount);
    @(negedge clk);
    swStoreReq = sw;
    storeReq = !sw;
    await(reqReady, "store taken");
    @(negedge clk);
    swStoreReq = 1'b0;
    storeReq = 1'b0;
    await(storeDone, "store done");
    check("store count", storeCount, expCount);
  endtask

  task automatic t_write_read();
    access(1'b1, 18'h00012, 16'ha5c3, 2'b11);
    access(1'b1, 18'h00012, 16'h7e00, 2'b10);
    access(1'b0, 18'h00012, 16'h0000, 2'b11);
    check("merged word", {16'h0, rdVal}, 32'h7ec3);
    access(1'b0, 18'h00012, 16'h0000, 2'b01);
    check("lower lane", {16'h0, rdVal}, 32'h00c3);
  endtask

  task automatic t_addr();
    access(1'b1, 18'h3ff34, 16'h1234, 2'b11);
    access(1'b1, 18'h00035, 16'h5678, 2'b11);
    access(1'b0, 18'h3ff34, 16'h0000, 2'b11);
    check("top address", {16'h0, rdVal}, 32'h1234);
    access(1'b0, 18'h00035, 16'h0000, 2'b11);
    check("next address", {16'h0, rdVal}, 32'h5678);
  endtask

  task automatic t_stores();
    store(1'b0, 1);
    store(1'b0, 1);
    store(1'b1, 2);
    access(1'b0, 18'h00012, 16'h0000, 2'b11);
    check("after store", {16'h0, rdVal}, 32'h7ec3);
  endtask

  // a third party pulls store-busy low while a write is under way
  task automatic t_pull_midwrite();
    @(negedge clk);
    req = '{write: 1'b1, addr: 19'h00050, wdata: 16'h9696, byteEn: 2'b11};
    reqValid = 1'b1;
    await(reqReady, "ready");
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    extPull = 1'b1;
    await(rspValid, "held write done");
    check("ready while pulled", {31'h0, reqReady}, 32'h0);
    @(negedge clk);
    extPull = 1'b0;
    access(1'b0, 18'h00050, 16'h0000, 2'b11);
    check("held write data", {16'h0, rdVal}, 32'h9696);
    check("pulled store count", storeCount, 3);
  endtask

  // supply dip after a write: automatic store, then recall
  task automatic t_power_dip();
    access(1'b1, 18'h00040, 16'h3c3c, 2'b11);
    @(negedge clk);
    supplyLow = 1'b1;
    @(negedge clk);
    supplyLow = 1'b0;
    // let the synchronised store-busy level reach the ready logic
    repeat (4) @(negedge clk);
    access(1'b0, 18'h00040, 16'h0000, 2'b11);
    check("dip data", {16'h0, rdVal}, 32'h3c3c);
    check("dip store count", storeCount, 4);
    check("recall count", recallCount, 1);
    store(1'b0, 4);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    repeat (3) @(posedge clk);
    t_write_read();
    t_addr();
    t_stores();
    t_pull_midwrite();
    t_power_dip();
    check("bus faults", protoErr, 0);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule
